// File: core/bertst_top.sv
// bit error rate tester: registers, receive checker, counters, error insert
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ns
module bertst_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // port controls
  input wire logic i_global_datapath_reset,
  input wire logic i_port_datapath_reset,
  input wire logic i_port_power_down,
  input wire logic i_tester_enable,
  input wire logic i_counter_update_request,
  input wire logic i_manual_error_insert,
  // serial data paths
  input wire logic i_tx_bit_en,
  output logic o_tx_data,
  input wire logic i_rx_bit_en,
  input wire logic i_rx_data,
  // status
  output logic o_oos,
  output logic o_update_complete,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack
);
  import bertst_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] pcfg;
    logic [15:0] eic;
    logic [15:0] ie;
    logic [31:0] seed;
    logic [3:0] latched;
    logic [23:0] err_cnt;
    logic [23:0] err_snap;
    logic [23:0] rate_cnt;
    logic [31:0] bit_cnt;
    logic [31:0] bit_snap;
    logic update_complete;
    logic trig_q;
    logic rx_ld_q;
    logic rx_ld_pend;
    logic tx_ld_q;
    logic tx_ld_pend;
    logic resync_q;
    logic in_sync;
    logic mtrig_q;
    logic ins_pend;
    logic tx_data;
    logic [5:0] match_cnt;
    logic [5:0] win_cnt;
    logic [2:0] win_err;
    logic [15:0] rdata;
  } bertst_st_t;

  bertst_st_t s;
  bertst_st_t next_s;

  logic clr;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_idx;
  logic tx_head;
  logic rx_fb;
  logic rx_in;
  logic mism;
  logic bit_inc;
  logic err_inc;
  logic resync_req;
  logic rx_ld;
  logic tx_ld;
  logic rx_exec;
  logic tx_exec;
  logic manual_resync;
  logic trig;
  logic mtrig;
  logic rate_hit;
  logic tx_err;
  logic [2:0] rate;
  logic [2:0] werr;
  logic [23:0] ecnt;
  logic [31:0] bcnt;
  logic [15:0] wval;
  logic [3:0] lclr;
  logic [3:0] lset;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] dat,
                                       input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction

  // bits between inserted errors, minus one
  function automatic logic [23:0] pow10m1(input logic [2:0] n);
    case (n)
      3'h1: return 24'h000009;
      3'h2: return 24'h000063;
      3'h3: return 24'h0003e7;
      3'h4: return 24'h00270f;
      3'h5: return 24'h01869f;
      3'h6: return 24'h0f423f;
      3'h7: return 24'h98967f;
      default: return 24'h000000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  bertst_gen_if cfg_if ();
  assign cfg_if.quasi_random_enable = s.pcfg[P_QUASI_RANDOM_ENABLE];
  assign cfg_if.pattern_type = s.pcfg[P_TYPE];
  assign cfg_if.length_position = s.pcfg[P_LEN_LSB +: 5];
  assign cfg_if.tap_position = s.pcfg[P_TAP_LSB +: 5];
  assign cfg_if.seed_value = s.seed;

  assign clr = i_global_datapath_reset | i_port_datapath_reset |
               i_port_power_down;

  bertst_wb u_wb (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_cyc(i_wb_cyc),
    .i_stb(i_wb_stb),
    .i_we(i_wb_we),
    .i_adr(i_wb_adr),
    .o_ack(o_wb_ack),
    .o_wr(bus_wr),
    .o_rd(bus_rd),
    .o_idx(bus_idx)
  );

  bertst_gen u_tx_gen (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_clr(clr),
    .i_ce(i_tx_bit_en),
    .i_load(tx_exec),
    .cfg(cfg_if),
    .i_ext_en(1'b0),
    .i_ext_bit(1'b0),
    .o_head(tx_head),
    .o_fb()
  );

  // while out of sync the receive side shifts in the line itself
  bertst_gen u_rx_gen (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_clr(clr),
    .i_ce(i_rx_bit_en),
    .i_load(rx_exec),
    .cfg(cfg_if),
    .i_ext_en(~s.in_sync),
    .i_ext_bit(rx_in),
    .o_head(),
    .o_fb(rx_fb)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    bit_inc = 1'b0;
    err_inc = 1'b0;
    resync_req = 1'b0;
    werr = s.win_err;
    wval = REG_RESET;
    lclr = 4'h0;
    rx_in = i_rx_data ^ s.ctrl[C_RX_INV];
    mism = rx_in ^ rx_fb;

    // load strobes wait for an enabled, running bit clock
    rx_ld = s.ctrl[C_RX_LOAD] & ~s.rx_ld_q;
    tx_ld = s.ctrl[C_TX_LOAD] & ~s.tx_ld_q;
    rx_exec = s.rx_ld_pend & i_tester_enable & i_rx_bit_en;
    tx_exec = s.tx_ld_pend & i_tester_enable & i_tx_bit_en;
    next_s.rx_ld_q = s.ctrl[C_RX_LOAD];
    next_s.tx_ld_q = s.ctrl[C_TX_LOAD];
    next_s.rx_ld_pend = (s.rx_ld_pend & ~rx_exec) | rx_ld;
    next_s.tx_ld_pend = (s.tx_ld_pend & ~tx_exec) | tx_ld;
    manual_resync = s.ctrl[C_RESYNC] & ~s.resync_q;
    next_s.resync_q = s.ctrl[C_RESYNC];

    // receive checking
    if (i_rx_bit_en) begin
      if (!s.in_sync) begin
        next_s.match_cnt = mism ? 6'h00 : s.match_cnt + 6'h01;
        if (!mism && (s.match_cnt == SYNC_MATCH - 6'h01)) begin
          next_s.in_sync = 1'b1;
          next_s.win_cnt = 6'h00;
          next_s.win_err = 3'h0;
        end
      end else begin
        bit_inc = 1'b1;
        err_inc = mism;
        if (mism && (s.win_err != 3'h7)) begin
          werr = s.win_err + 3'h1;
        end
        next_s.win_cnt = s.win_cnt + 6'h01;
        next_s.win_err = (s.win_cnt == WINDOW_LAST) ? 3'h0 : werr;
        if ((werr >= RESYNC_ERRS) && !s.ctrl[C_AUTO_DIS]) begin
          resync_req = 1'b1;
        end
      end
    end
    if (resync_req | manual_resync | rx_exec) begin
      next_s.in_sync = 1'b0;
      next_s.match_cnt = 6'h00;
    end

    // counters and snapshot
    trig = s.ctrl[C_UPD_SEL] ? i_counter_update_request
                             : s.ctrl[C_LOCAL_UPD];
    next_s.trig_q = trig;
    ecnt = (&s.err_cnt) ? s.err_cnt : s.err_cnt + 24'(err_inc);
    bcnt = (&s.bit_cnt) ? s.bit_cnt : s.bit_cnt + 32'(bit_inc);
    if (trig & ~s.trig_q) begin
      next_s.err_snap = ecnt;
      next_s.bit_snap = bcnt;
      next_s.err_cnt = 24'(err_inc);
      next_s.bit_cnt = 32'(bit_inc);
      next_s.update_complete = 1'b1;
    end else begin
      next_s.err_cnt = ecnt;
      next_s.bit_cnt = bcnt;
    end
    // complete drops with the trigger, so software must hold it
    if (!trig) begin
      next_s.update_complete = 1'b0;
    end

    // transmit path and error insertion
    rate = s.eic[E_RATE_LSB +: 3];
    rate_hit = i_tx_bit_en & (rate != 3'h0) & (s.rate_cnt == 24'h000000);
    if (i_tx_bit_en && (rate != 3'h0)) begin
      next_s.rate_cnt = rate_hit ? pow10m1(rate) : s.rate_cnt - 24'h000001;
    end
    mtrig = s.eic[E_MEIMS] ? i_manual_error_insert : s.eic[E_TSEI];
    next_s.mtrig_q = mtrig;
    tx_err = rate_hit | (i_tx_bit_en & s.ins_pend);
    // an edge landing on the insertion bit is kept for the next bit
    next_s.ins_pend = (s.ins_pend & ~i_tx_bit_en) |
                      (mtrig & ~s.mtrig_q & s.eic[E_BEI]);
    if (i_tx_bit_en) begin
      next_s.tx_data = tx_head ^ s.ctrl[C_TX_INV] ^ tx_err;
    end

    // register reads, captured the cycle before ack
    if (bus_rd) begin
      case (bus_idx)
        IDX_CTRL: next_s.rdata = s.ctrl;
        IDX_PCFG: next_s.rdata = s.pcfg;
        IDX_SEED_LO: next_s.rdata = s.seed[15:0];
        IDX_SEED_HI: next_s.rdata = s.seed[31:16];
        IDX_EIC: next_s.rdata = s.eic;
        IDX_STAT: next_s.rdata = {12'h000, s.update_complete, 1'b0,
                                  s.err_snap != 24'h000000, ~s.in_sync};
        IDX_LATCH: next_s.rdata = {12'h000, s.latched};
        IDX_IE: next_s.rdata = s.ie;
        IDX_ERR_LO: next_s.rdata = s.err_snap[15:0];
        IDX_ERR_HI: next_s.rdata = {8'h00, s.err_snap[23:16]};
        IDX_BIT_LO: next_s.rdata = s.bit_snap[15:0];
        IDX_BIT_HI: next_s.rdata = s.bit_snap[31:16];
        default: next_s.rdata = REG_RESET;
      endcase
    end

    // register writes, taken on the ack edge
    if (bus_wr) begin
      case (bus_idx)
        IDX_CTRL: next_s.ctrl = wr16(s.ctrl, i_wb_dat, i_wb_sel) & CTRL_MASK;
        IDX_PCFG: next_s.pcfg = wr16(s.pcfg, i_wb_dat, i_wb_sel) & PCFG_MASK;
        IDX_SEED_LO: next_s.seed[15:0] = wr16(s.seed[15:0], i_wb_dat,
                                              i_wb_sel);
        IDX_SEED_HI: next_s.seed[31:16] = wr16(s.seed[31:16], i_wb_dat,
                                               i_wb_sel);
        IDX_EIC: begin
          wval = wr16(s.eic, i_wb_dat, i_wb_sel) & EIC_MASK;
          next_s.eic = wval;
          // a running rate finishes its current error before changing to another nonzero rate; writing rate 0 stops it at once
          if ((rate == 3'h0) && (wval[E_RATE_LSB +: 3] != 3'h0)) begin
            next_s.rate_cnt = pow10m1(wval[E_RATE_LSB +: 3]);
          end
        end
        IDX_LATCH: begin
          wval = wr16(REG_RESET, i_wb_dat, i_wb_sel);
          lclr = wval[3:0];
        end
        IDX_IE: next_s.ie = wr16(s.ie, i_wb_dat, i_wb_sel) & FLAG_MASK;
        default: ;
      endcase
    end

    // sticky flags: a set in the clearing cycle wins
    lset = {next_s.update_complete & ~s.update_complete, err_inc,
            (next_s.err_snap != 24'h000000) & (s.err_snap == 24'h000000),
            next_s.in_sync ^ s.in_sync};
    next_s.latched = (s.latched & ~lclr) | lset;

    if (clr) begin
      next_s = '0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_tx_data = s.tx_data;
  assign o_oos = ~s.in_sync;
  assign o_update_complete = s.update_complete;
  assign o_wb_dat = {16'h0000, s.rdata};
endmodule

// File: common/bertst_pkg.sv
// constants shared by the bit error rate tester design
package bertst_pkg;
  // ----------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL = 8'h60;
  localparam logic [7:0] IDX_PCFG = 8'h62;
  localparam logic [7:0] IDX_SEED_LO = 8'h64;
  localparam logic [7:0] IDX_SEED_HI = 8'h66;
  localparam logic [7:0] IDX_EIC = 8'h68;
  localparam logic [7:0] IDX_STAT = 8'h6c;
  localparam logic [7:0] IDX_LATCH = 8'h6e;
  localparam logic [7:0] IDX_IE = 8'h70;
  localparam logic [7:0] IDX_ERR_LO = 8'h74;
  localparam logic [7:0] IDX_ERR_HI = 8'h76;
  localparam logic [7:0] IDX_BIT_LO = 8'h78;
  localparam logic [7:0] IDX_BIT_HI = 8'h7a;
  // ----------------------------------------------------------------
  // field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int C_TX_INV = 0;
  localparam int C_TX_LOAD = 1;
  localparam int C_AUTO_DIS = 2;
  localparam int C_RESYNC = 3;
  localparam int C_RX_INV = 4;
  localparam int C_RX_LOAD = 5;
  localparam int C_LOCAL_UPD = 6;
  localparam int C_UPD_SEL = 7;
  localparam int P_LEN_LSB = 0;
  localparam int P_TYPE = 5;
  localparam int P_QUASI_RANDOM_ENABLE = 6;
  localparam int P_TAP_LSB = 8;
  localparam int E_MEIMS = 0;
  localparam int E_TSEI = 1;
  localparam int E_BEI = 2;
  localparam int E_RATE_LSB = 3;
  localparam logic [15:0] CTRL_MASK = 16'h00ff;
  localparam logic [15:0] PCFG_MASK = 16'h1f7f;
  localparam logic [15:0] EIC_MASK = 16'h003f;
  localparam logic [15:0] FLAG_MASK = 16'h000f;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // counts
  // ----------------------------------------------------------------
  localparam logic [5:0] SYNC_MATCH = 6'h20;
  localparam logic [5:0] WINDOW_LAST = 6'h3f;
  localparam logic [2:0] RESYNC_ERRS = 3'h6;
  localparam logic [4:0] QUASI_RANDOM_ENABLE_LEN = 5'h13;
  localparam logic [4:0] QUASI_RANDOM_ENABLE_TAP = 5'h10;
endpackage

// File: common/bertst_gen_if.sv
// pattern configuration carried from the registers to both generators
`timescale 1ns/1ns
interface bertst_gen_if;
  logic quasi_random_enable;
  logic pattern_type;
  logic [4:0] length_position;
  logic [4:0] tap_position;
  logic [31:0] seed_value;
  modport src (output quasi_random_enable, pattern_type, length_position, tap_position,
               seed_value);
  modport gen (input quasi_random_enable, pattern_type, length_position, tap_position,
               seed_value);
endinterface

// File: core/bertst_wb.sv
// classic wishbone handshake and index decode for the tester registers
`timescale 1ns/1ns
module bertst_wb (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // bus request
  input wire logic i_cyc,
  input wire logic i_stb,
  input wire logic i_we,
  input wire logic [9:0] i_adr,
  // decoded strobes
  output logic o_ack,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_idx
);
  logic req;
  // one wait state: read data is captured the cycle before ack
  assign req = i_cyc & i_stb;
  assign o_wr = req & o_ack & i_we;
  assign o_rd = req & ~o_ack;
  assign o_idx = i_adr[9:2];
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ack <= 1'b0;
    end else begin
      o_ack <= req & ~o_ack;
    end
  end
endmodule

// File: core/bertst_gen.sv
// 32-bit shift register pattern generator shared by transmit and receive
`timescale 1ns/1ns
module bertst_gen (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clr,
  // bit strobe, load and configuration
  input wire logic i_ce,
  input wire logic i_load,
  bertst_gen_if.gen cfg,
  // external bit shifted in while hunting for sync
  input wire logic i_ext_en,
  input wire logic i_ext_bit,
  // pattern outputs
  output logic o_head,
  output logic o_fb
);
  import bertst_pkg::*;
  typedef struct packed {
    logic [31:0] sr;
    logic [4:0] len;
    logic [4:0] tap;
    logic rep;
    logic quasi_random_enable;
  } bertst_gst_t;
  bertst_gst_t s;
  bertst_gst_t next_s;
  always_comb begin
    next_s = s;
    // repetitive patterns ignore the tap and rotate bit n alone
    o_fb = s.rep ? s.sr[s.len] : s.sr[s.len] ^ s.sr[s.tap];
    // zero suppression looks at the next 14 bits behind the head
    o_head = s.sr[s.len] | (s.quasi_random_enable & (s.sr[18:5] == 14'h0000));
    if (i_load) begin
      next_s.sr = cfg.seed_value;
      next_s.quasi_random_enable = cfg.quasi_random_enable;
      next_s.rep = cfg.quasi_random_enable ? 1'b0 : cfg.pattern_type;
      next_s.len = cfg.quasi_random_enable ? QUASI_RANDOM_ENABLE_LEN : cfg.length_position;
      next_s.tap = cfg.quasi_random_enable ? QUASI_RANDOM_ENABLE_TAP : cfg.tap_position;
    end else if (i_ce) begin
      next_s.sr = {s.sr[30:0], i_ext_en ? i_ext_bit : o_fb};
    end
    if (i_clr) begin
      next_s = '0;
    end
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// File: dv/bertst_line.sv
// serial line model: strobes the tester and loops tx back into rx
`timescale 1ns/1ns
module bertst_line (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // bench control
  input wire logic i_run,
  input wire logic i_slow,
  // tester side
  input wire logic i_tx_data,
  output logic o_tx_bit_en,
  output logic o_rx_bit_en,
  output logic o_rx_data
);
  logic [1:0] div;
  logic tx_seen;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div <= 2'h0;
      tx_seen <= 1'b0;
      o_tx_bit_en <= 1'b0;
      o_rx_bit_en <= 1'b0;
      o_rx_data <= 1'b0;
    end else begin
      div <= div + 2'h1;
      // slow mode: one bit every fourth cycle
      o_tx_bit_en <= i_run && (!i_slow || div == 2'h0);
      tx_seen <= o_tx_bit_en;
      o_rx_bit_en <= tx_seen;
      // toggles between bits so a stale bit never looks valid
      o_rx_data <= tx_seen ? i_tx_data : ~o_rx_data;
    end
  end
endmodule

// File: dv/bertst_monitor.sv
// port-level assertions for the bit error rate tester
`timescale 1ns/1ns
module bertst_monitor (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // port controls
  input wire logic i_global_datapath_reset,
  input wire logic i_port_datapath_reset,
  input wire logic i_port_power_down,
  // serial paths and status
  input wire logic i_tx_bit_en,
  input wire logic o_tx_data,
  input wire logic i_rx_bit_en,
  input wire logic o_oos,
  input wire logic o_update_complete,
  // bus
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack
);
  // ----------------------------------------------------------------
  // helper: rx bits seen while hunting
  // ----------------------------------------------------------------
  logic [6:0] hunt_bits;
  logic any_clr;
  assign any_clr = i_global_datapath_reset | i_port_datapath_reset |
                   i_port_power_down;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // saturates so a long hunt cannot wrap back under the bound
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      hunt_bits <= 7'h0;
    else if (!o_oos)
      hunt_bits <= 7'h0;
    else if (i_rx_bit_en && hunt_bits != 7'h7f)
      hunt_bits <= hunt_bits + 7'h1;
  end
  chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property ($rose(i_wb_cyc && i_wb_stb) |=> o_wb_ack)
    else $error("ack not one cycle after request");
  chk_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  chk_dat_upper: assert property (o_wb_ack |-> o_wb_dat[31:16] == 16'h0)
    else $error("upper read data not zero");
  chk_global_clear: assert property (
    i_global_datapath_reset |=> o_oos && !o_update_complete)
    else $error("global clear left state");
  chk_port_clear: assert property (
    i_port_datapath_reset |=> o_oos && !o_update_complete)
    else $error("port clear left state");
  chk_power_clear: assert property (
    i_port_power_down |=> o_oos && !o_update_complete)
    else $error("power down left state");
  chk_tx_hold: assert property (
    !i_tx_bit_en && !any_clr |=> $stable(o_tx_data))
    else $error("tx bit moved without strobe");
  chk_sync_bits: assert property (
    $fell(o_oos) |-> hunt_bits >= 7'd32)
    else $error("sync declared too early");
endmodule
bind bertst_top bertst_monitor u_mon (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_global_datapath_reset(i_global_datapath_reset),
  .i_port_datapath_reset(i_port_datapath_reset),
  .i_port_power_down(i_port_power_down), .i_tx_bit_en(i_tx_bit_en),
  .o_tx_data(o_tx_data), .i_rx_bit_en(i_rx_bit_en), .o_oos(o_oos),
  .o_update_complete(o_update_complete), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack)
);

// File: dv/tb_bit_error_rate_tester.sv
// register-level testbench for the bit error rate tester
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
  fail_count++; end end
`define WAIT(c) begin n = 0; while (!(c) && n < 3000) begin \
  @(posedge clk); n++; end if (n >= 3000) begin fail_count++; \
  print_verdict(); end end
module tb_bit_error_rate_tester;
  import bertst_pkg::*;
  logic clk = 0, rst = 1, gdr = 0, pdr = 0, ppd = 0, ten = 0, cur = 0;
  logic cyc = 0, stb = 0, we = 0, run = 0, slow = 0, mei = 0;
  logic [9:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] dat = '0;
  logic txd, ooss, upd, ack, tx_en, rx_en, rx_d;
  logic [31:0] rdat, q, cap;
  logic [15:0] ctrl;
  logic [7:0] rst_idx [6] = '{IDX_CTRL, IDX_PCFG, IDX_SEED_LO, IDX_SEED_HI,
                              IDX_EIC, IDX_IE};
  int fail_count = 0, compares = 0, k, n, i;
  bertst_top dut (
    .i_clk(clk), .i_sys_rst(rst), .i_global_datapath_reset(gdr),
    .i_port_datapath_reset(pdr), .i_port_power_down(ppd),
    .i_tester_enable(ten), .i_counter_update_request(cur),
    .i_manual_error_insert(mei), .i_tx_bit_en(tx_en), .o_tx_data(txd),
    .i_rx_bit_en(rx_en), .i_rx_data(rx_d), .o_oos(ooss),
    .o_update_complete(upd), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
    .o_wb_dat(rdat), .o_wb_ack(ack)
  );
  bertst_line u_line (
    .i_clk(clk), .i_sys_rst(rst), .i_run(run), .i_slow(slow),
    .i_tx_data(txd), .o_tx_bit_en(tx_en), .o_rx_bit_en(rx_en),
    .o_rx_data(rx_d)
  );
  initial forever #50 clk = ~clk;
  // ----------------------------------------------------------------
  // bus and line tasks
  // ----------------------------------------------------------------
  task print_verdict;
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [15:0] d);
    int t;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h3;
    dat <= {16'h0, d};
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (t >= 20) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task wr(input logic [7:0] idx, input logic [15:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rd_chk(string nm, input logic [7:0] idx,
                        input logic [15:0] e);
    xfer(1'b0, idx, 16'h0);
    `CHK(nm, e, q[15:0])
  endtask
  task set_ctrl(input logic [15:0] v);
    ctrl = v;
    wr(IDX_CTRL, v);
  endtask
  // loads with strobes stopped so the first strobe is the load
  task automatic tx_grab(input logic [15:0] c);
    @(posedge clk);
    run <= 1'b0;
    set_ctrl(c & 16'hfffd);
    set_ctrl(c);
    @(posedge clk);
    run <= 1'b1;
    k = 0;
    n = 0;
    while (k < 33 && n < 200) begin
      @(posedge clk);
      n++;
      if (tx_en === 1'b1) begin
        k++;
        #1;
        if (k >= 2) cap = {cap[30:0], txd};
      end
    end
    if (k < 33) begin
      fail_count++;
      print_verdict();
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    ctrl = 16'h0;
    cap = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rst_idx[j]) rd_chk("reset value", rst_idx[j], REG_RESET);
    rd_chk("status", IDX_STAT, 16'h0001);
    wr(8'h6a, 16'hffff);
    rd_chk("unmapped", 8'h6a, 16'h0000);
    wr(IDX_ERR_LO, 16'hffff);
    rd_chk("read only", IDX_ERR_LO, 16'h0000);
    wr(IDX_PCFG, 16'hffff);
    rd_chk("pcfg mask", IDX_PCFG, PCFG_MASK);
    wr(IDX_SEED_LO, 16'h1234);
    wr(IDX_SEED_HI, 16'hc5a3);
    rd_chk("seed low", IDX_SEED_LO, 16'h1234);
    rd_chk("seed high", IDX_SEED_HI, 16'hc5a3);
    // repetitive, n = 31, tap set but unused
    wr(IDX_PCFG, 16'h0a3f);
    tx_grab(16'h0002);
    `CHK("load while disabled", 32'h0, cap)
    @(posedge clk);
    ten <= 1'b1;
    for (i = 0; i < 2; i++) begin
      tx_grab(16'h0002 | 16'(i));
      `CHK("tx pattern", 32'hc5a31234 ^ {32{i[0]}}, cap)
    end
    @(posedge clk);
    slow <= 1'b1;
    set_ctrl(16'h0022);
    `WAIT(ooss === 1'b0)
    set_ctrl(ctrl | 16'h0008);
    repeat (8) @(posedge clk);
    `CHK("manual resync", 1'b1, ooss)
    `WAIT(ooss === 1'b0)
    set_ctrl(ctrl & 16'hffd7);
    set_ctrl(ctrl | 16'h0020);
    repeat (8) @(posedge clk);
    `CHK("rx reload", 1'b1, ooss)
    `WAIT(ooss === 1'b0)
    set_ctrl(ctrl | 16'h0010);
    `WAIT(ooss === 1'b1)
    `WAIT(ooss === 1'b0)
    set_ctrl((ctrl | 16'h0004) & 16'hffef);
    repeat (400) @(posedge clk);
    `CHK("auto resync off", 1'b0, ooss)
    set_ctrl(ctrl | 16'h0040);
    `WAIT(upd === 1'b1)
    rd_chk("status complete", IDX_STAT, 16'h0008 | (q[15:0] & 16'h0002));
    xfer(1'b0, IDX_BIT_LO, 16'h0);
    `CHK("bits counted", 1'b1, q[15:0] != 16'h0)
    set_ctrl(ctrl & 16'hffbf);
    `WAIT(upd === 1'b0)
    set_ctrl(ctrl | 16'h0080);
    set_ctrl(ctrl | 16'h0040);
    repeat (6) @(posedge clk);
    `CHK("local ignored", 1'b0, upd)
    cur <= 1'b1;
    `WAIT(upd === 1'b1)
    cur <= 1'b0;
    `WAIT(upd === 1'b0)
    for (i = 0; i < 3; i++) begin
      wr(IDX_SEED_LO, 16'hbeef);
      @(posedge clk);
      {ppd, pdr, gdr} <= 3'(1 << i);
      @(posedge clk);
      {ppd, pdr, gdr} <= 3'h0;
      rd_chk("cleared seed", IDX_SEED_LO, REG_RESET);
      rd_chk("cleared ctrl", IDX_CTRL, REG_RESET);
    end
    print_verdict();
  end
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule
